// file: cfm_pkg.sv
package cfm_pkg;
  // register byte offsets
  localparam logic [7:0]  A_LOSS_CTL   = 8'h00;
  localparam logic [7:0]  A_NMI_FLAG   = 8'h04;
  localparam logic [7:0]  A_NMI_CLR    = 8'h08;
  localparam logic [7:0]  A_NMI_FRC    = 8'h0C;
  localparam logic [7:0]  A_NWD_PRD    = 8'h10;
  localparam logic [7:0]  A_NWD_CNT    = 8'h14;
  localparam logic [7:0]  A_NMI_SHADOW = 8'h18;
  localparam logic [7:0]  A_RST_CAUSE  = 8'h1C;
  localparam logic [7:0]  A_PCLK_GATE  = 8'h20;
  localparam logic [7:0]  A_SOFT_RST   = 8'h24;
  localparam logic [7:0]  A_LOCK       = 8'h28;
  localparam logic [7:0]  A_WD_CTL     = 8'h2C;
  localparam logic [7:0]  A_WD_PRD     = 8'h30;
  localparam logic [7:0]  A_WD_WIN     = 8'h34;
  localparam logic [7:0]  A_WD_KEY     = 8'h38;
  localparam logic [7:0]  A_WD_CNT     = 8'h3C;
  localparam logic [7:0]  A_SW_RST     = 8'h40;
  // keys
  localparam logic [15:0] CTL_KEY      = 16'hA5C3;
  localparam logic [15:0] WD_GOOD_KEY  = 16'h0055;
  // field positions
  localparam int          LOSS_OFF_BIT  = 0;
  localparam int          LOSS_TEST_BIT = 1;
  localparam int          LOSS_STS_BIT  = 8;
  localparam int          WD_INT_BIT   = 0;
  localparam int          WD_WIN_BIT   = 1;
  localparam int          LOCK_GATE_BIT = 0;
  localparam int          NF_CLK       = 0;
  localparam int          NF_EXT       = 1;
  localparam int          NF_W         = 2;
  localparam int          RC_POR       = 0;
  localparam int          RC_NWD       = 1;
  localparam int          RC_WD        = 2;
  localparam int          RC_SW        = 3;
  localparam int          RC_PERIPH    = 4;
  localparam int          RC_W         = 5;
  // reset values
  localparam logic [15:0] NWD_PRD_RST   = 16'h0FFF;
  localparam logic [15:0] WD_PRD_RST    = 16'h0FFF;
  localparam logic [15:0] WD_WIN_RST    = 16'h0000;
  localparam logic [RC_W-1:0] RC_RST    = 5'h01;
  // timing
  localparam int          CLK_HZ       = 200_000_000;
  localparam int          OSC_HZ       = 10_000_000;
  localparam int          OSC_DIV      = CLK_HZ / OSC_HZ;
  localparam int          LOSS_LIMIT   = 8;
endpackage : cfm_pkg

// file: cfm_sync.sv
`timescale 1ns/1ps
module cfm_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : cfm_sync

// file: cfm_monitor.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1 - loss detector ticks at 10 MHz, flags only total loss of reference clock
// R2 - loss detector active from power-on; software may disable it
// R3 - pending NMI not recovered before timeout requests a device reset
// R4 - NMI watchdog timeout is a software-written period register
// R5 - NMI shadow copy cleared only by power-on reset, kept over warm reset
// R6 - NMI flags copied into shadow before warm reset is requested
// R7 - critical control writes take effect only with correct upper key
// R8 - each peripheral clock gated individually; gated after reset
// R9 - gating configuration can be locked against later writes
// R10 - each peripheral soft reset individual; none asserted after reset
// R11 - reset cause register latches the source of the latest reset event
// R12 - error status pin signals a critical internal error
// R13 - forcing the clock fail bit sets its flag and the error pin
// R14 - oscillator-off test bit simulates loss: sets flag and status
// R15 - non-power-on resets triggerable internally, record cause, act narrowly
// R16 - watchdog failure raises interrupt instead of reset when selected
// R17 - watchdog lower and upper bounds define the service window
// R18 - watchdog errors on expiry or on a wrong service key
// R19 - windowed mode errors when key arrives before the lower bound
// R20 - NMI watchdog counts while any flag set, clears when all cleared
// R21 - external monitor treats error pin assertion as critical fault
module cfm_monitor #(
  parameter int NP        = 8,
  parameter int LOSS_LIMIT = cfm_pkg::LOSS_LIMIT
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          power_on_reset_n,
  input  wire logic [7:0]    paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          pll_ref_clk,
  input  wire logic          ext_fault_in,
  output logic               nmi_out,
  output logic               error_status_pin,
  output logic               warm_reset_req,
  output logic               wdog_irq,
  output logic      [NP-1:0] periph_clk_en,
  output logic      [NP-1:0] periph_soft_reset
);
  localparam int DW = $clog2(cfm_pkg::OSC_DIV);
  localparam int MW = $clog2(LOSS_LIMIT + 1);

  logic                  loss_det_off, osc_off_test_bit, missing_clock_status;
  logic [cfm_pkg::NF_W-1:0] nmi_flag_reg, nmi_shadow, flag_set, flag_clr;
  logic [15:0]           nmi_watchdog_period, nwd_cnt;
  logic [cfm_pkg::RC_W-1:0] reset_cause_reg;
  logic                  lock_gate;
  logic                  wdog_interrupt_select, wd_window_en;
  logic [15:0]           wd_period, wd_win_low, wd_cnt;
  logic [DW-1:0]         osc_div;
  logic                  osc_tick;
  logic [MW-1:0]         loss_cnt;
  logic                  ref_s, ref_d, ext_s;
  logic [31:0]           next_prdata;
  logic                  hit;

  wire setup  = psel & ~penable;
  wire acc    = psel & penable & pready;
  wire wr     = acc & pwrite;
  wire key_ok = pwdata[31:16] == cfm_pkg::CTL_KEY;
  wire kwr    = wr & key_ok; // [R7]

  cfm_sync #(.W(2)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      ({ext_fault_in, pll_ref_clk}),
    .dout     ({ext_s, ref_s})
  );

  // apb slave: no wait states, data registered in setup
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    hit         = 1'b1;
    case (paddr)
      cfm_pkg::A_LOSS_CTL: begin
        next_prdata[cfm_pkg::LOSS_OFF_BIT]  = loss_det_off;
        next_prdata[cfm_pkg::LOSS_TEST_BIT] = osc_off_test_bit;
        next_prdata[cfm_pkg::LOSS_STS_BIT]  = missing_clock_status;
      end
      cfm_pkg::A_NMI_FLAG:   next_prdata[cfm_pkg::NF_W-1:0] = nmi_flag_reg;
      cfm_pkg::A_NMI_CLR:    next_prdata = 32'h0000_0000;
      cfm_pkg::A_NMI_FRC:    next_prdata = 32'h0000_0000;
      cfm_pkg::A_NWD_PRD:    next_prdata[15:0] = nmi_watchdog_period;
      cfm_pkg::A_NWD_CNT:    next_prdata[15:0] = nwd_cnt;
      cfm_pkg::A_NMI_SHADOW: next_prdata[cfm_pkg::NF_W-1:0] = nmi_shadow;
      cfm_pkg::A_RST_CAUSE:  next_prdata[cfm_pkg::RC_W-1:0] = reset_cause_reg;
      cfm_pkg::A_PCLK_GATE:  next_prdata[NP-1:0] = periph_clk_en;
      cfm_pkg::A_SOFT_RST:   next_prdata[NP-1:0] = periph_soft_reset;
      cfm_pkg::A_LOCK:       next_prdata[cfm_pkg::LOCK_GATE_BIT] = lock_gate;
      cfm_pkg::A_WD_CTL: begin
        next_prdata[cfm_pkg::WD_INT_BIT] = wdog_interrupt_select;
        next_prdata[cfm_pkg::WD_WIN_BIT] = wd_window_en;
      end
      cfm_pkg::A_WD_PRD:     next_prdata[15:0] = wd_period;
      cfm_pkg::A_WD_WIN:     next_prdata[15:0] = wd_win_low;
      cfm_pkg::A_WD_KEY:     next_prdata = 32'h0000_0000;
      cfm_pkg::A_WD_CNT:     next_prdata[15:0] = wd_cnt;
      cfm_pkg::A_SW_RST:     next_prdata = 32'h0000_0000;
      default:               hit = 1'b0;
    endcase
  end

  // internal oscillator rate as an enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_div  <= '0;
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= osc_div == DW'(cfm_pkg::OSC_DIV - 1);
      osc_div  <= (osc_div == DW'(cfm_pkg::OSC_DIV - 1)) ? '0 : osc_div + 1'b1;
    end
  end

  // missing clock detector control
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_det_off     <= 1'b0; // [R2]
      osc_off_test_bit <= 1'b0;
    end else if (kwr && paddr == cfm_pkg::A_LOSS_CTL) begin
      loss_det_off     <= pwdata[cfm_pkg::LOSS_OFF_BIT]; // [R2]
      osc_off_test_bit <= pwdata[cfm_pkg::LOSS_TEST_BIT];
    end
  end

  // any rising reference edge restarts the count unless osc_off_test_bit masks it, so only a full stop is seen
  wire ref_edge = ref_s & ~ref_d & ~osc_off_test_bit; // [R14]
  wire ref_loss = ~loss_det_off & (loss_cnt == MW'(LOSS_LIMIT)); // [R1]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d    <= 1'b0;
      loss_cnt <= '0;
    end else begin
      ref_d <= ref_s;
      if (loss_det_off || ref_edge) begin
        loss_cnt <= '0;
      end else if (osc_tick && loss_cnt != MW'(LOSS_LIMIT)) begin
        loss_cnt <= loss_cnt + 1'b1; // [R1]
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      missing_clock_status <= 1'b0;
    end else begin
      if (wr && paddr == cfm_pkg::A_LOSS_CTL && pwdata[cfm_pkg::LOSS_STS_BIT]) begin
        missing_clock_status <= 1'b0;
      end
      if (ref_loss) begin
        missing_clock_status <= 1'b1; // [R14]
      end
    end
  end

  // nmi flags: set beats clear
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[cfm_pkg::NF_CLK] = ref_loss; // [R14]
    flag_set[cfm_pkg::NF_EXT] = ext_s;
    if (wr && paddr == cfm_pkg::A_NMI_FRC) begin
      flag_set = flag_set | pwdata[cfm_pkg::NF_W-1:0]; // [R13]
    end
    if (wr && paddr == cfm_pkg::A_NMI_CLR) begin
      flag_clr = pwdata[cfm_pkg::NF_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_flag_reg     <= '0;
      nmi_out          <= 1'b0;
      error_status_pin <= 1'b0;
    end else begin
      nmi_flag_reg     <= (nmi_flag_reg & ~flag_clr) | flag_set;
      nmi_out          <= |nmi_flag_reg;
      error_status_pin <= |nmi_flag_reg; // [R12] [R13]
    end
  end

  // nmi recovery watchdog
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_watchdog_period <= cfm_pkg::NWD_PRD_RST;
    end else if (kwr && paddr == cfm_pkg::A_NWD_PRD) begin
      nmi_watchdog_period <= pwdata[15:0]; // [R4]
    end
  end

  wire nwd_fire = (|nmi_flag_reg) & (nwd_cnt == nmi_watchdog_period); // [R3]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nwd_cnt <= 16'h0000;
    end else if (nmi_flag_reg == '0) begin
      nwd_cnt <= 16'h0000; // [R20]
    end else if (nwd_cnt != nmi_watchdog_period) begin
      nwd_cnt <= nwd_cnt + 16'h0001; // [R20]
    end
  end

  // peripheral clock gating and soft reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_gate <= 1'b0;
    end else if (kwr && paddr == cfm_pkg::A_LOCK && pwdata[cfm_pkg::LOCK_GATE_BIT]) begin
      lock_gate <= 1'b1; // [R9]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_clk_en <= '0; // [R8]
    end else if (kwr && paddr == cfm_pkg::A_PCLK_GATE && !lock_gate) begin
      periph_clk_en <= pwdata[NP-1:0]; // [R8] [R9]
    end
  end

  wire soft_wr = kwr && paddr == cfm_pkg::A_SOFT_RST;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_soft_reset <= '0; // [R10]
    end else if (soft_wr) begin
      periph_soft_reset <= pwdata[NP-1:0]; // [R10] [R15]
    end
  end

  // internal watchdog
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_interrupt_select <= 1'b0;
      wd_window_en          <= 1'b0;
      wd_period             <= cfm_pkg::WD_PRD_RST;
      wd_win_low            <= cfm_pkg::WD_WIN_RST;
    end else if (kwr) begin
      if (paddr == cfm_pkg::A_WD_CTL) begin
        wdog_interrupt_select <= pwdata[cfm_pkg::WD_INT_BIT]; // [R16]
        wd_window_en          <= pwdata[cfm_pkg::WD_WIN_BIT];
      end
      if (paddr == cfm_pkg::A_WD_PRD) begin
        wd_period <= pwdata[15:0]; // [R17]
      end
      if (paddr == cfm_pkg::A_WD_WIN) begin
        wd_win_low <= pwdata[15:0]; // [R17]
      end
    end
  end

  wire wd_svc    = wr && paddr == cfm_pkg::A_WD_KEY;
  wire wd_early  = wd_window_en & (wd_cnt < wd_win_low); // [R17] [R19]
  wire wd_good   = wd_svc & (pwdata[15:0] == cfm_pkg::WD_GOOD_KEY) & ~wd_early;
  wire wd_expire = osc_tick & (wd_cnt == wd_period); // [R18]
  wire wd_err    = (wd_svc & ~wd_good) | wd_expire; // [R18] [R19]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt <= 16'h0000;
    end else if (wd_good || wd_err) begin
      wd_cnt <= 16'h0000;
    end else if (osc_tick) begin
      wd_cnt <= wd_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_irq <= 1'b0;
    end else begin
      wdog_irq <= wd_err & wdog_interrupt_select; // [R16]
    end
  end

  // internal reset requests; the request holds until warm reset clears it
  wire req_wd  = wd_err & ~wdog_interrupt_select; // [R16]
  wire req_sw  = kwr && paddr == cfm_pkg::A_SW_RST && pwdata[0]; // [R15]
  wire any_req = nwd_fire | req_wd | req_sw; // [R3]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_reset_req <= 1'b0;
    end else if (any_req) begin
      warm_reset_req <= 1'b1; // [R3] [R15]
    end
  end

  // power-on domain: survives warm reset
  always_ff @(posedge core_clk or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      nmi_shadow <= '0; // [R5]
    end else if (any_req && !warm_reset_req) begin
      nmi_shadow <= nmi_flag_reg; // [R6]
    end
  end

  always_ff @(posedge core_clk or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      reset_cause_reg <= cfm_pkg::RC_RST;
    end else if (!warm_reset_req) begin
      if (nwd_fire) begin
        reset_cause_reg <= cfm_pkg::RC_W'(1 << cfm_pkg::RC_NWD); // [R11]
      end else if (req_wd) begin
        reset_cause_reg <= cfm_pkg::RC_W'(1 << cfm_pkg::RC_WD); // [R11]
      end else if (req_sw) begin
        reset_cause_reg <= cfm_pkg::RC_W'(1 << cfm_pkg::RC_SW); // [R15]
      end else if (soft_wr && pwdata[NP-1:0] != '0) begin
        reset_cause_reg <= cfm_pkg::RC_W'(1 << cfm_pkg::RC_PERIPH); // [R15]
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_ref_loss;
    ref_loss |=> missing_clock_status && nmi_flag_reg[cfm_pkg::NF_CLK];
  endproperty
  a_ref_loss: assert property (p_ref_loss) else $error("loss not flagged"); // [R1]

  property p_loss_off;
    loss_det_off && !missing_clock_status |=> !missing_clock_status;
  endproperty
  a_loss_off: assert property (p_loss_off) else $error("disabled detector fired"); // [R2]

  property p_nwd_fire;
    nwd_fire && !warm_reset_req
      |=> warm_reset_req && nmi_shadow == $past(nmi_flag_reg);
  endproperty
  a_nwd_fire: assert property (p_nwd_fire) else $error("nmi timeout missed"); // [R3]

  property p_nwd_idle;
    nmi_flag_reg == '0 |=> nwd_cnt == 16'h0000;
  endproperty
  a_nwd_idle: assert property (p_nwd_idle) else $error("nmi counter not cleared"); // [R20]

  property p_bad_key;
    wr && !key_ok && paddr == cfm_pkg::A_PCLK_GATE |=> $stable(periph_clk_en);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("keyless write accepted"); // [R7]

  property p_lock;
    lock_gate |=> $stable(periph_clk_en) && lock_gate;
  endproperty
  a_lock: assert property (p_lock) else $error("locked gating changed"); // [R9]

  property p_force_err;
    wr && paddr == cfm_pkg::A_NMI_FRC && pwdata[cfm_pkg::NF_CLK]
      |=> nmi_flag_reg[cfm_pkg::NF_CLK] ##1 error_status_pin;
  endproperty
  a_force_err: assert property (p_force_err) else $error("forced flag lost"); // [R13]

  property p_wd_irq;
    wd_err && wdog_interrupt_select && !any_req && !warm_reset_req
      |=> wdog_irq && !warm_reset_req;
  endproperty
  a_wd_irq: assert property (p_wd_irq) else $error("watchdog irq mode wrong"); // [R16]

  property p_wd_early;
    wd_svc && wd_early && !warm_reset_req
      |=> wdog_irq || warm_reset_req;
  endproperty
  a_wd_early: assert property (p_wd_early) else $error("early service ignored"); // [R19]

  c_loss:  cover property (ref_loss);
  c_nwd:   cover property (nwd_fire);
  c_wdirq: cover property (wdog_irq);
endmodule : cfm_monitor

// file: cfm_ext_mon.sv
`timescale 1ns/1ps
module cfm_ext_mon (
  input  wire logic core_clk,
  input  wire logic power_on_reset_n,
  input  wire logic error_status_pin,
  output logic      safe_state
);
  // any error pin assertion moves the system to safe state until power cycle
  always_ff @(posedge core_clk or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      safe_state <= 1'b0;
    end else if (error_status_pin) begin
      safe_state <= 1'b1;
    end
  end
endmodule : cfm_ext_mon

// file: tb_clock_fail_nmi_reset_monitor.sv
`timescale 1ns/1ps
module tb_clock_fail_nmi_reset_monitor;
  localparam int ML = 2;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        power_on_reset_n = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        pll_ref_clk = 1'b0;
  logic        ext_fault_in = 1'b0;
  logic        ref_run = 1'b1;
  logic [31:0] prdata;
  logic        pready, pslverr, nmi_out, error_status_pin;
  logic        warm_reset_req, wdog_irq, safe_state;
  logic [7:0]  periph_clk_en, periph_soft_reset, g, s;
  logic [31:0] lfsr = 32'hD854;
  logic [32:0] cur;
  logic [32:0] exp_q[$];
  string       nm_q[$];
  int          n_fail = 0;
  int          samples_checked = 0;
  int          n_irq = 0;
  int          n0;
  cfm_monitor #(.NP(8), .LOSS_LIMIT(ML)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .power_on_reset_n(power_on_reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pll_ref_clk(pll_ref_clk),
    .ext_fault_in(ext_fault_in), .nmi_out(nmi_out), .error_status_pin(error_status_pin),
    .warm_reset_req(warm_reset_req), .wdog_irq(wdog_irq), .periph_clk_en(periph_clk_en),
    .periph_soft_reset(periph_soft_reset));
  cfm_ext_mon mon (.core_clk(core_clk), .power_on_reset_n(power_on_reset_n),
    .error_status_pin(error_status_pin), .safe_state(safe_state));
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (ref_run) pll_ref_clk <= ~pll_ref_clk;
  always @(posedge core_clk) if (wdog_irq === 1'b1) n_irq <= n_irq + 1;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  function automatic logic [31:0] kw(input logic [15:0] v);
    return {cfm_pkg::CTL_KEY, v};
  endfunction : kw
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    samples_checked++;
    if (v !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, v);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    xfer(a, 1'b0, 32'h0);
  endtask : rd
  // read results are compared against the oldest note when the access completes
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      cur = exp_q.pop_front();
      chk(nm_q[0], cur[31:0], prdata);
      chk("pslverr", 32'(cur[32]), 32'(pslverr));
      void'(nm_q.pop_front());
    end
  end
  task automatic warm(input string nm, input int lo, input int hi);
    int t;
    t = 0;
    while (warm_reset_req !== 1'b1 && t < hi) begin
      @(posedge core_clk);
      t++;
    end
    chk(nm, 32'h1, 32'(t >= lo && warm_reset_req === 1'b1));
    @(posedge core_clk);
    rst_n        <= 1'b0;
    ext_fault_in <= 1'b0;
    cyc(3);
    chk("req_in_reset", 32'h0, 32'(warm_reset_req));
    @(posedge core_clk);
    rst_n <= 1'b1;
  endtask : warm
  task automatic tally_and_finish;
    if (exp_q.size() != 0) n_fail++;
    $display("TB: checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n            <= 1'b1;
    power_on_reset_n <= 1'b1;
    cyc(1);
    chk("clk_en_rst", 32'h0, 32'(periph_clk_en));
    chk("soft_rst_rst", 32'h0, 32'(periph_soft_reset));
    rd("cause_por", cfm_pkg::A_RST_CAUSE, 33'h1);
    rd("loss_ctl_rst", cfm_pkg::A_LOSS_CTL, 33'h0);
    rd("unmapped", 8'h44, {1'b1, 32'h0});
    lfsr = lfsr_next(lfsr);
    g = lfsr[7:0] | 8'h01;
    wr(cfm_pkg::A_PCLK_GATE, {16'h1234, 8'h00, g});
    cyc(2);
    chk("gate_badkey", 32'h0, 32'(periph_clk_en));
    wr(cfm_pkg::A_PCLK_GATE, kw({8'h00, g}));
    cyc(2);
    chk("gate_on", 32'(g), 32'(periph_clk_en));
    wr(cfm_pkg::A_LOCK, kw(16'h0001));
    wr(cfm_pkg::A_PCLK_GATE, kw({8'h00, ~g}));
    cyc(2);
    chk("gate_locked", 32'(g), 32'(periph_clk_en));
    lfsr = lfsr_next(lfsr);
    s = lfsr[7:0] | 8'h80;
    wr(cfm_pkg::A_SOFT_RST, kw({8'h00, s}));
    cyc(2);
    chk("soft_rst", 32'(s), 32'(periph_soft_reset));
    chk("gate_kept", 32'(g), 32'(periph_clk_en));
    chk("no_warm", 32'h0, 32'(warm_reset_req));
    rd("cause_periph", cfm_pkg::A_RST_CAUSE, 33'h10);
    wr(cfm_pkg::A_SOFT_RST, kw(16'h0000));
    wr(cfm_pkg::A_NMI_FRC, 32'h1);
    cyc(2);
    chk("err_pin_frc", 32'h1, 32'(error_status_pin));
    chk("safe_state", 32'h1, 32'(safe_state));
    rd("flag_frc", cfm_pkg::A_NMI_FLAG, 33'h1);
    wr(cfm_pkg::A_NMI_CLR, 32'h1);
    cyc(2);
    chk("err_pin_clr", 32'h0, 32'(error_status_pin));
    rd("nwd_cnt_clr", cfm_pkg::A_NWD_CNT, 33'h0);
    wr(cfm_pkg::A_LOSS_CTL, kw(16'h0002));
    cyc(ML * 20 + 40);
    rd("loss_test", cfm_pkg::A_LOSS_CTL, 33'h102);
    rd("flag_loss", cfm_pkg::A_NMI_FLAG, 33'h1);
    chk("nmi_out", 32'h1, 32'(nmi_out));
    wr(cfm_pkg::A_LOSS_CTL, kw(16'h0000));
    wr(cfm_pkg::A_LOSS_CTL, 32'h100);
    wr(cfm_pkg::A_NMI_CLR, 32'h1);
    rd("loss_cleared", cfm_pkg::A_LOSS_CTL, 33'h0);
    ref_run <= 1'b0;
    cyc(ML * 20 + 40);
    rd("ref_loss", cfm_pkg::A_LOSS_CTL, 33'h100);
    ref_run <= 1'b1;
    wr(cfm_pkg::A_LOSS_CTL, kw(16'h0001));
    wr(cfm_pkg::A_LOSS_CTL, 32'h100);
    wr(cfm_pkg::A_NMI_CLR, 32'h3);
    ref_run <= 1'b0;
    cyc(ML * 20 + 40);
    rd("loss_off", cfm_pkg::A_LOSS_CTL, 33'h1);
    ref_run <= 1'b1;
    wr(cfm_pkg::A_NWD_PRD, 32'h28);
    rd("nwd_prd_key", cfm_pkg::A_NWD_PRD, 33'h0FFF);
    wr(cfm_pkg::A_NWD_PRD, kw(16'h0028));
    rd("nwd_prd", cfm_pkg::A_NWD_PRD, 33'h28);
    ext_fault_in <= 1'b1;
    warm("nwd_fire", 40, 50);
    cyc(2);
    rd("shadow", cfm_pkg::A_NMI_SHADOW, 33'h2);
    rd("cause_nwd", cfm_pkg::A_RST_CAUSE, 33'h2);
    chk("gate_warm", 32'h0, 32'(periph_clk_en));
    wr(cfm_pkg::A_SW_RST, 32'h1);
    cyc(4);
    chk("sw_badkey", 32'h0, 32'(warm_reset_req));
    wr(cfm_pkg::A_SW_RST, kw(16'h0001));
    warm("sw_req", 0, 10);
    cyc(2);
    rd("cause_sw", cfm_pkg::A_RST_CAUSE, 33'h8);
    wr(cfm_pkg::A_WD_CTL, kw(16'h0001));
    n0 = n_irq;
    wr(cfm_pkg::A_WD_KEY, 32'h1234);
    cyc(3);
    chk("wd_badkey", 32'(n0 + 1), 32'(n_irq));
    chk("wd_int_mode", 32'h0, 32'(warm_reset_req));
    wr(cfm_pkg::A_WD_WIN, kw(16'h0004));
    wr(cfm_pkg::A_WD_KEY, 32'(cfm_pkg::WD_GOOD_KEY));
    wr(cfm_pkg::A_WD_CTL, kw(16'h0003));
    wr(cfm_pkg::A_WD_KEY, 32'(cfm_pkg::WD_GOOD_KEY));
    cyc(3);
    chk("wd_early", 32'(n0 + 2), 32'(n_irq));
    cyc(120);
    wr(cfm_pkg::A_WD_KEY, 32'(cfm_pkg::WD_GOOD_KEY));
    cyc(3);
    chk("wd_in_window", 32'(n0 + 2), 32'(n_irq));
    wr(cfm_pkg::A_WD_CTL, kw(16'h0001));
    wr(cfm_pkg::A_WD_PRD, kw(16'h0003));
    wr(cfm_pkg::A_WD_KEY, 32'(cfm_pkg::WD_GOOD_KEY));
    cyc(100);
    chk("wd_expire", 32'h1, 32'(n_irq > n0 + 2));
    wr(cfm_pkg::A_NMI_FRC, 32'h2);
    wr(cfm_pkg::A_WD_CTL, kw(16'h0000));
    warm("wd_reset", 0, 200);
    cyc(2);
    rd("cause_wd", cfm_pkg::A_RST_CAUSE, 33'h4);
    rd("shadow_wd", cfm_pkg::A_NMI_SHADOW, 33'h2);
    @(posedge core_clk);
    rst_n            <= 1'b0;
    power_on_reset_n <= 1'b0;
    cyc(3);
    @(posedge core_clk);
    rst_n            <= 1'b1;
    power_on_reset_n <= 1'b1;
    rd("shadow_cold", cfm_pkg::A_NMI_SHADOW, 33'h0);
    rd("cause_cold", cfm_pkg::A_RST_CAUSE, 33'h1);
    cyc(2);
    tally_and_finish();
  end
endmodule : tb_clock_fail_nmi_reset_monitor
